/* File: hw/lam_pkg.sv */
// package: register map, encodings and timing constants for the monitor
package lam_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_SPARE_SRC = 4'h1;
   localparam logic [3:0] REG_EXPOSURE = 4'h2;
   localparam logic [3:0] REG_OVERLAP = 4'h3;
   localparam logic [3:0] REG_READOUT = 4'h4;
   localparam logic [3:0] REG_WAIT_STATUS = 4'h5;
   localparam logic [3:0] REG_SW_TRIG = 4'h6;
   // control field positions
   localparam int CTRL_MODE_BIT = 0;
   localparam int CTRL_NOLIMIT_BIT = 1;
   localparam int CTRL_ENABLE_BIT = 2;
   // reset values
   localparam logic [2:0] CTRL_RESET = 3'h4;
   localparam logic [1:0] SPARE_RESET = 2'h0;
   localparam logic [15:0] EXPOSURE_RESET = 16'h0014;
   localparam logic [15:0] OVERLAP_RESET = 16'h0046;
   localparam logic [15:0] READOUT_RESET = 16'h0080;
   // overlap upper limit unless removed, raw units
   localparam logic [15:0] OVERLAP_MAX = 16'h03E8;
   // spare output sources
   localparam logic [1:0] SRC_EXPOSURE = 2'h0;
   localparam logic [1:0] SRC_TRIG_READY = 2'h1;
   localparam logic [1:0] SRC_FREQ_CONV = 2'h2;
   // time base: one raw count is 100 ns; abs us times 10 gives raw
   localparam int TIME_BASE_NS = 100;
   localparam int CLK_PERIOD_NS = 10;
   localparam int ABS_TO_RAW = 10;
   localparam int TICK_CYCLES = TIME_BASE_NS / CLK_PERIOD_NS;
   localparam logic [3:0] TICK_LAST = 4'(TICK_CYCLES - 1);
   typedef enum {
      LAM_ST_IDLE,
      LAM_ST_WAIT,
      LAM_ST_EXPOSE,
      LAM_ST_HOLD
   } lam_state_type;
endpackage : lam_pkg

/* File: hw/lam_timer_if.sv */
// interface: timebase counter request and done between monitor and timer
`timescale 1ns/1ps
`default_nettype none
interface lam_timer_if;
   logic start;
   logic [15:0] count;
   logic done;
   logic busy;
   modport ctl (output start, output count, input done, input busy);
   modport tmr (input start, input count, output done, output busy);
endinterface : lam_timer_if
`default_nettype wire

/* File: hw/lam_timer.sv */
// module: counts raw 100 ns time-base units for the monitor
`timescale 1ns/1ps
`default_nettype none
module lam_timer
(
   input wire logic core_clk,
   input wire logic rst,
   lam_timer_if.tmr tif
);
   logic [3:0] tick_q;
   logic [15:0] left_q;
   logic busy_q;
   logic done_q;
   wire tick_end = (tick_q == lam_pkg::TICK_LAST);
   wire last_unit = tick_end && (left_q <= 16'h0001);

   // each raw count is one time-base unit of 100 ns
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         tick_q <= 4'h0;
         left_q <= 16'h0000;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else if (tif.start)
      begin
         tick_q <= 4'h0;
         left_q <= tif.count;
         busy_q <= 1'b1;
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= busy_q && last_unit;
         busy_q <= busy_q && !last_unit;
         tick_q <= (tick_end || !busy_q) ? 4'h0 : tick_q + 4'h1;
         if (busy_q && tick_end)
         begin
            left_q <= left_q - 16'h0001;
         end
      end
   end
   assign tif.done = done_q;
   assign tif.busy = busy_q;
endmodule : lam_timer
`default_nettype wire

/* File: hw/lam_monitor.sv */
// module: line acquisition monitor with status and spare output routing
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module lam_monitor
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic hw_line_start_trigger,
   input wire logic freq_conv_out,
   output logic exposure_active,
   output logic waiting_trigger_choice,
   output logic spare_output_line
);
   // ====================================================
   // registers
   logic [2:0] ctrl_q;
   logic [1:0] spare_src_q;
   logic [15:0] exposure_q;
   logic [15:0] overlap_q;
   logic [15:0] readout_q;
   logic [15:0] rdata_q;
   logic trig_prev_q;
   logic sw_trig_q;
   logic expo_q;
   logic wait_q;
   logic spare_q;
   logic [15:0] ro_left_q;
   logic ro_run_q;
   lam_pkg::lam_state_type state_q;
   lam_pkg::lam_state_type state_d;

   lam_timer_if tif ();
   lam_timer u_timer
   (
      .core_clk(core_clk),
      .rst(rst),
      .tif(tif)
   );

   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      hit = (a == r);
   endfunction : hit

   // ====================================================
   // decode
   wire width_mode = ctrl_q[lam_pkg::CTRL_MODE_BIT];
   wire no_limit = ctrl_q[lam_pkg::CTRL_NOLIMIT_BIT];
   wire enable = ctrl_q[lam_pkg::CTRL_ENABLE_BIT];
   wire wr_ctrl = reg_wr && hit(reg_addr, lam_pkg::REG_CTRL);
   wire wr_src = reg_wr && hit(reg_addr, lam_pkg::REG_SPARE_SRC);
   wire wr_exp = reg_wr && hit(reg_addr, lam_pkg::REG_EXPOSURE);
   wire wr_ovl = reg_wr && hit(reg_addr, lam_pkg::REG_OVERLAP);
   wire wr_ro = reg_wr && hit(reg_addr, lam_pkg::REG_READOUT);
   wire wr_sw = reg_wr && hit(reg_addr, lam_pkg::REG_SW_TRIG);
   // limit applies unless removed; write is clamped
   wire ovl_clamp = !no_limit && (reg_wdata > lam_pkg::OVERLAP_MAX);
   // raw value is abs us times ten, i.e. 100 ns units
   wire [15:0] ovl_wval = ovl_clamp ? lam_pkg::OVERLAP_MAX : reg_wdata;
   wire hw_rise = hw_line_start_trigger && !trig_prev_q;
   wire waiting = (state_q == lam_pkg::LAM_ST_WAIT);
   // triggers count only in the waiting state
   wire take_trig = waiting && (hw_rise || sw_trig_q);
   // timed mode waits out the exposure, width mode the overlap register value
   wire [15:0] hold_cnt =
      width_mode ? overlap_q : exposure_q;
   wire readout_done = !ro_run_q;
   wire timer_idle = !tif.busy && !tif.start;

   // ====================================================
   // acquisition state
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         lam_pkg::LAM_ST_IDLE:
            if (enable)
               state_d = lam_pkg::LAM_ST_WAIT;
         lam_pkg::LAM_ST_WAIT:
            if (!enable)
               state_d = lam_pkg::LAM_ST_IDLE;
            else if (take_trig)
               state_d = lam_pkg::LAM_ST_EXPOSE;
         lam_pkg::LAM_ST_EXPOSE:
            if (tif.done)
               state_d = lam_pkg::LAM_ST_HOLD;
         lam_pkg::LAM_ST_HOLD:
            // wait again once readout and timer end
            if (readout_done && timer_idle)
               state_d = lam_pkg::LAM_ST_WAIT;
         default:
            state_d = lam_pkg::LAM_ST_IDLE;
      endcase
   end

   assign tif.start = take_trig;
   assign tif.count = hold_cnt;

   // ====================================================
   // configuration and state flops
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_q <= lam_pkg::CTRL_RESET;
         spare_src_q <= lam_pkg::SPARE_RESET;
         exposure_q <= lam_pkg::EXPOSURE_RESET;
         overlap_q <= lam_pkg::OVERLAP_RESET;
         readout_q <= lam_pkg::READOUT_RESET;
         state_q <= lam_pkg::LAM_ST_IDLE;
         trig_prev_q <= 1'b0;
         sw_trig_q <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= reg_wdata[2:0];
         if (wr_src)
            spare_src_q <= reg_wdata[1:0];
         if (wr_exp)
            exposure_q <= reg_wdata;
         if (wr_ovl)
            overlap_q <= ovl_wval;
         if (wr_ro)
            readout_q <= reg_wdata;
         state_q <= state_d;
         trig_prev_q <= hw_line_start_trigger;
         // one-cycle request; lost if the state is not waiting
         sw_trig_q <= wr_sw && reg_wdata[0];
      end
   end

   // ====================================================
   // readout of the previous line runs from each accepted trigger
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         ro_left_q <= 16'h0000;
         ro_run_q <= 1'b0;
      end
      else if (take_trig)
      begin
         ro_left_q <= readout_q;
         ro_run_q <= (readout_q != 16'h0000);
      end
      else if (ro_run_q)
      begin
         ro_left_q <= ro_left_q - 16'h0001;
         ro_run_q <= (ro_left_q > 16'h0001);
      end
   end

   // ====================================================
   // outputs, all registered
   wire expo_d = (state_d == lam_pkg::LAM_ST_EXPOSE);
   wire wait_d = (state_d == lam_pkg::LAM_ST_WAIT);
   wire [15:0] rd_val =
      hit(reg_addr, lam_pkg::REG_CTRL) ? {13'h0000, ctrl_q} :
      hit(reg_addr, lam_pkg::REG_SPARE_SRC) ? {14'h0000, spare_src_q} :
      hit(reg_addr, lam_pkg::REG_EXPOSURE) ? exposure_q :
      hit(reg_addr, lam_pkg::REG_OVERLAP) ? overlap_q :
      hit(reg_addr, lam_pkg::REG_READOUT) ? readout_q :
      // read-only view of the same wait state
      hit(reg_addr, lam_pkg::REG_WAIT_STATUS) ? {15'h0000, wait_q} :
      16'h0000;
   logic spare_d;
   always_comb
   begin
      case (spare_src_q)
         lam_pkg::SRC_EXPOSURE: spare_d = expo_d;
         lam_pkg::SRC_TRIG_READY: spare_d = wait_d;
         lam_pkg::SRC_FREQ_CONV: spare_d = freq_conv_out;
         default: spare_d = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         expo_q <= 1'b0;
         wait_q <= 1'b0;
         spare_q <= 1'b0;
         rdata_q <= 16'h0000;
      end
      else
      begin
         expo_q <= expo_d;
         wait_q <= wait_d;
         spare_q <= spare_d;
         rdata_q <= reg_rd ? rd_val : 16'h0000;
      end
   end

   assign exposure_active = expo_q;
   assign waiting_trigger_choice = wait_q;
   assign spare_output_line = spare_q;
   assign reg_rdata = rdata_q;

   // ====================================================
   // checks
   a_wait_tracks_state: assert property (@(posedge core_clk)
      disable iff (rst)
      waiting_trigger_choice == (state_q == lam_pkg::LAM_ST_WAIT))
      else $error("wait output differs from wait state");

   a_trig_drops_wait: assert property (@(posedge core_clk)
      disable iff (rst)
      (waiting && hw_rise && enable) |=> !waiting_trigger_choice)
      else $error("wait did not fall on trigger");

   a_busy_ignores_trig: assert property (@(posedge core_clk)
      disable iff (rst)
      (!waiting && state_q != lam_pkg::LAM_ST_IDLE) |=> !$rose(tif.busy))
      else $error("trigger accepted while not ready");

   a_sw_ignored: assert property (@(posedge core_clk)
      disable iff (rst)
      (sw_trig_q && !waiting) |=> $stable(state_q))
      else $error("software trigger acted while busy");

   a_expo_follows: assert property (@(posedge core_clk)
      disable iff (rst)
      take_trig |=> exposure_active)
      else $error("exposure not active after trigger");

   a_status_read: assert property (@(posedge core_clk)
      disable iff (rst)
      (reg_rd && hit(reg_addr, lam_pkg::REG_WAIT_STATUS))
      |=> reg_rdata == {15'h0000, $past(wait_q)})
      else $error("status read mismatch");

   a_spare_expo: assert property (@(posedge core_clk)
      disable iff (rst)
      (spare_src_q == lam_pkg::SRC_EXPOSURE && !wr_src)
      |=> spare_output_line == exposure_active)
      else $error("spare line not exposure active");

   a_spare_wait: assert property (@(posedge core_clk)
      disable iff (rst)
      (spare_src_q == lam_pkg::SRC_TRIG_READY && !wr_src)
      |=> spare_output_line == waiting_trigger_choice)
      else $error("spare line not trigger wait");

   a_overlap_limit: assert property (@(posedge core_clk)
      disable iff (rst)
      (wr_ovl && !no_limit) |=> overlap_q <= lam_pkg::OVERLAP_MAX)
      else $error("overlap exceeds limit");

   a_expo_tracks: assert property (@(posedge core_clk)
      disable iff (rst)
      exposure_active == (state_q == lam_pkg::LAM_ST_EXPOSE))
      else $error("exposure output differs from exposure state");

   // a stale readout must never let the next trigger in early
   a_wait_ready: assert property (@(posedge core_clk)
      disable iff (rst)
      $rose(waiting_trigger_choice) |-> readout_done && !tif.busy)
      else $error("wait rose before readout and timer ended");

   a_readout_gate: assert property (@(posedge core_clk)
      disable iff (rst)
      (state_q == lam_pkg::LAM_ST_HOLD && ro_run_q)
      |=> !waiting_trigger_choice)
      else $error("wait rose while readout still running");

   a_spare_freq: assert property (@(posedge core_clk)
      disable iff (rst)
      (spare_src_q == lam_pkg::SRC_FREQ_CONV && !wr_src)
      |=> spare_output_line == $past(freq_conv_out))
      else $error("spare line not converter output");

   a_overlap_kept: assert property (@(posedge core_clk)
      disable iff (rst)
      (wr_ovl && no_limit) |=> overlap_q == $past(reg_wdata))
      else $error("overlap changed although limit removed");

   a_overlap_clamp: assert property (@(posedge core_clk)
      disable iff (rst)
      (wr_ovl && ovl_clamp) |=> overlap_q == lam_pkg::OVERLAP_MAX)
      else $error("overlap not clamped to limit");

   // idle monitor shows neither exposure nor readiness
   a_idle_quiet: assert property (@(posedge core_clk)
      disable iff (rst)
      (state_q == lam_pkg::LAM_ST_IDLE)
      |-> !exposure_active && !waiting_trigger_choice)
      else $error("idle monitor drives exposure or wait");
endmodule : lam_monitor
`default_nettype wire

/* File: sim/lam_trig_src.sv */
// model: line trigger source that fires while the monitor waits, or at any time when force_fire is set
`timescale 1ns/1ps
`default_nettype none
module lam_trig_src
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic fire,
   input wire logic force_fire,
   input wire logic waiting_trigger_choice,
   output logic hw_line_start_trigger
);
   logic [2:0] hold_q;
   // ==========================================================
   // trigger pulse
   // force_fire breaks the handshake on purpose, for overtrigger cases
   wire logic start =
      fire && (waiting_trigger_choice || force_fire);
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         hold_q <= 3'h0;
         hw_line_start_trigger <= 1'b0;
      end
      else if (hold_q != 3'h0)
      begin
         hold_q <= hold_q - 3'h1;
         hw_line_start_trigger <= (hold_q != 3'h1);
      end
      else if (start)
      begin
         hold_q <= 3'h4;
         hw_line_start_trigger <= 1'b1;
      end
   end
endmodule : lam_trig_src
`default_nettype wire

/* File: sim/tb_lam_monitor.sv */
// testbench: registers, trigger handshake and spare line of the monitor
`timescale 1ns/1ps
`default_nettype none
module tb_lam_monitor;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0, reg_rd = 1'b0, fire = 1'b0, force_fire = 1'b0;
   logic freq_conv_out = 1'b0;
   logic [15:0] reg_rdata;
   logic trig, expo, waiting, spare;
   int fail_count = 0, checks = 0, cycles = 0;
   // ==========================================================
   // instances and clock
   lam_monitor lam_monitor_inst (.core_clk(core_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_line_start_trigger(trig),
      .freq_conv_out(freq_conv_out), .exposure_active(expo),
      .waiting_trigger_choice(waiting), .spare_output_line(spare));
   lam_trig_src lam_trig_src_inst (.core_clk(core_clk), .rst(rst),
      .fire(fire), .force_fire(force_fire),
      .waiting_trigger_choice(waiting), .hw_line_start_trigger(trig));
   initial forever #5 core_clk = ~core_clk;
   // the whole run needs about 3000 cycles
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         end_sim();
      end
   end
   // ==========================================================
   // shared tasks
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rd_chk
   task automatic pulse(input logic forced);
      @(posedge core_clk);
      fire <= 1'b1;
      force_fire <= forced;
      @(posedge core_clk);
      fire <= 1'b0;
      force_fire <= 1'b0;
   endtask : pulse
   task automatic wait_sig(input logic ex, input logic v, input int n);
      for (int k = 0; k < n; k++)
      begin
         @(posedge core_clk);
         #1;
         if ((ex ? expo : waiting) === v)
            break;
      end
   endtask : wait_sig
   // one line: trigger, measure exposure, optional overtriggers inside it
   task automatic line(input logic sw, input logic over, input int lo,
      input int hi);
      int t0;
      if (sw)
         wr(lam_pkg::REG_SW_TRIG, 16'h0001);
      else
         pulse(1'b0);
      wait_sig(1'b1, 1'b1, 10);
      chk({15'h0, expo}, 16'h0001);
      chk({15'h0, waiting}, 16'h0000);
      t0 = cycles;
      if (over)
      begin
         rd_chk(lam_pkg::REG_WAIT_STATUS, 16'h0000);
         wr(lam_pkg::REG_WAIT_STATUS, 16'h0001);
         pulse(1'b1);
         wr(lam_pkg::REG_SW_TRIG, 16'h0001);
      end
      wait_sig(1'b1, 1'b0, 4000);
      t0 = cycles - t0;
      chk(16'(t0 >= lo && t0 <= hi), 16'h0001);
      wait_sig(1'b0, 1'b1, 300);
      chk({15'h0, waiting}, 16'h0001);
      if (over)
      begin
         repeat (5) @(posedge core_clk);
         #1 chk({15'h0, expo}, 16'h0000);
         rd_chk(lam_pkg::REG_WAIT_STATUS, 16'h0001);
      end
   endtask : line
   // ==========================================================
   // scenarios
   task automatic t_reset();
      rd_chk(lam_pkg::REG_CTRL, {13'h0, lam_pkg::CTRL_RESET});
      rd_chk(lam_pkg::REG_SPARE_SRC, {14'h0, lam_pkg::SPARE_RESET});
      rd_chk(lam_pkg::REG_EXPOSURE, lam_pkg::EXPOSURE_RESET);
      rd_chk(lam_pkg::REG_OVERLAP, lam_pkg::OVERLAP_RESET);
      rd_chk(lam_pkg::REG_READOUT, lam_pkg::READOUT_RESET);
      rd_chk(4'h7, 16'h0000);
      rd_chk(lam_pkg::REG_WAIT_STATUS, 16'h0001);
      $display("test reset done");
   endtask : t_reset
   task automatic t_timed();
      int t0;
      wr(lam_pkg::REG_EXPOSURE, 16'h0003);
      wr(lam_pkg::REG_READOUT, 16'h0010);
      line(1'b0, 1'b0, 29, 33);
      line(1'b1, 1'b0, 29, 33);
      line(1'b0, 1'b1, 29, 33);
      // readout longer than exposure: wait must hold until readout ends
      wr(lam_pkg::REG_READOUT, 16'h0040);
      pulse(1'b0);
      wait_sig(1'b1, 1'b1, 10);
      t0 = cycles;
      wait_sig(1'b0, 1'b1, 300);
      t0 = cycles - t0;
      chk(16'(t0 >= 64 && t0 <= 67), 16'h0001);
      $display("test timed done");
   endtask : t_timed
   task automatic t_limit();
      wr(lam_pkg::REG_OVERLAP, 16'h07D0);
      rd_chk(lam_pkg::REG_OVERLAP, lam_pkg::OVERLAP_MAX);
      wr(lam_pkg::REG_CTRL, 16'h0006);
      wr(lam_pkg::REG_OVERLAP, 16'h07D0);
      rd_chk(lam_pkg::REG_OVERLAP, 16'h07D0);
      // 15 us as shortest intended exposure, times ten in raw units
      wr(lam_pkg::REG_CTRL, 16'h0005);
      wr(lam_pkg::REG_OVERLAP, 16'h0096);
      line(1'b0, 1'b0, 1499, 1503);
      $display("test limit done");
   endtask : t_limit
   task automatic t_spare();
      wr(lam_pkg::REG_SPARE_SRC, {14'h0, lam_pkg::SRC_FREQ_CONV});
      freq_conv_out <= 1'b1; // held several cycles to be seen
      repeat (3) @(posedge core_clk);
      #1 chk({15'h0, spare}, 16'h0001);
      @(posedge core_clk);
      freq_conv_out <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 chk({15'h0, spare}, 16'h0000);
      wr(lam_pkg::REG_SPARE_SRC, {14'h0, lam_pkg::SRC_TRIG_READY});
      repeat (3) @(posedge core_clk);
      #1 chk({15'h0, spare}, 16'h0001);
      wr(lam_pkg::REG_SPARE_SRC, {14'h0, lam_pkg::SRC_EXPOSURE});
      pulse(1'b0);
      wait_sig(1'b1, 1'b1, 10);
      repeat (2) @(posedge core_clk);
      #1 chk({15'h0, spare}, 16'h0001);
      wait_sig(1'b0, 1'b1, 2000);
      chk({15'h0, spare}, 16'h0000);
      wr(lam_pkg::REG_SPARE_SRC, 16'h0003);
      repeat (3) @(posedge core_clk);
      #1 chk({15'h0, spare}, 16'h0000);
      $display("test spare done");
   endtask : t_spare
   initial
   begin
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_timed();
      t_limit();
      t_spare();
      end_sim();
   end
endmodule : tb_lam_monitor
`default_nettype wire
